// file: include/tdcc_pkg.sv
// tdcc_pkg: register map, field positions, reset values and timing for the dual capture timer
package tdcc_pkg;

  // ******************************************************************
  // register byte addresses (printed offset 0x16 is not a multiple of four)
  // ******************************************************************
  localparam logic [7:0] CTRL3_IDX = 8'h16;
  localparam logic [11:0] CTRL3_ADDR = 12'h058; // index times four
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] CNT_LO_ADDR = 12'h004;
  localparam logic [11:0] CNT_HI_ADDR = 12'h008;
  localparam logic [11:0] CAPA_LO_ADDR = 12'h00c;
  localparam logic [11:0] CAPA_HI_ADDR = 12'h010;
  localparam logic [11:0] CAPB_LO_ADDR = 12'h014;
  localparam logic [11:0] CAPB_HI_ADDR = 12'h018;

  // ******************************************************************
  // control register fields
  // ******************************************************************
  localparam int CTRL_PWM_BIT = 0;
  localparam int CTRL_EDA_LSB = 1;
  localparam int CTRL_EDB_LSB = 3;
  localparam int CTRL_OVFA_BIT = 5;
  localparam int CTRL_OVFB_BIT = 6;
  localparam logic [7:0] CTRL_WMASK = 8'h1f;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // configuration register fields
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_SRC_BIT = 1;
  localparam int CFG_DIR_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // ******************************************************************
  // edge select codes and timing
  // ******************************************************************
  typedef enum logic [1:0]
  {
    TDCC_EDGE_FALL = 2'h0,
    TDCC_EDGE_RISE = 2'h1,
    TDCC_EDGE_RISE4 = 2'h2,
    TDCC_EDGE_RISE16 = 2'h3
  } tdcc_edge_t;

  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_CYCLE_NS = 40; // four device clocks per instruction cycle
  localparam int INSTR_DIV = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int PHASE_DIV = INSTR_DIV / 2; // two samples per instruction cycle

endpackage : tdcc_pkg

// file: verilog/tdcc_capture_chan.sv
// tdcc_capture_chan: one capture channel with edge prescale and overflow hold
module tdcc_capture_chan
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // capture pin and mode
  input wire logic cap_in,
  input wire logic [1:0] edge_sel,
  input wire logic [15:0] counter_val,
  // software read tracking
  input wire logic rd_lo,
  input wire logic rd_hi,
  // results
  output logic [15:0] cap_val_r,
  output logic overflow_r,
  output logic cap_event
);

  logic cap_d_r;
  logic [3:0] pre_cnt_r;
  logic unread_r;
  logic lo_seen_r;
  logic hi_seen_r;
  logic rise;
  logic fall;
  logic both_read;
  logic load;

  assign rise = cap_in && !cap_d_r;
  assign fall = !cap_in && cap_d_r;
  assign both_read = (rd_lo || lo_seen_r) && (rd_hi || hi_seen_r);
  // an unread value blocks the load until both bytes have been read
  assign load = cap_event && !(unread_r && !both_read);

  // edge history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap_d_r <= 1'b0;
    else
      cap_d_r <= cap_in;
  end

  // rising edge prescaler for the every-4th and every-16th modes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_cnt_r <= 4'h0;
    else if (rise)
      pre_cnt_r <= pre_cnt_r + 4'h1;
  end

  // event decode per edge select code
  always_comb
  begin
    case (tdcc_pkg::tdcc_edge_t'(edge_sel))
      tdcc_pkg::TDCC_EDGE_FALL: cap_event = fall;
      tdcc_pkg::TDCC_EDGE_RISE: cap_event = rise;
      tdcc_pkg::TDCC_EDGE_RISE4: cap_event = rise && (pre_cnt_r[1:0] == 2'h3);
      default: cap_event = rise && (pre_cnt_r == 4'hf);
    endcase
  end

  // track reads of both bytes since the last load
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lo_seen_r <= 1'b0;
      hi_seen_r <= 1'b0;
    end
    else if (both_read || load) // a stale low-byte read must not complete a fresh pair
    begin
      lo_seen_r <= 1'b0;
      hi_seen_r <= 1'b0;
    end
    else
    begin
      lo_seen_r <= lo_seen_r || rd_lo;
      hi_seen_r <= hi_seen_r || rd_hi;
    end
  end

  // load, unread and overflow; an event in the read-complete cycle loads anew
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_val_r <= 16'h0000;
      unread_r <= 1'b0;
      overflow_r <= 1'b0;
    end
    else if (cap_event && unread_r && !both_read)
      overflow_r <= 1'b1;
    else if (cap_event)
    begin
      cap_val_r <= counter_val;
      unread_r <= 1'b1;
      overflow_r <= 1'b0;
    end
    else if (both_read)
    begin
      unread_r <= 1'b0;
      overflow_r <= 1'b0;
    end
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  a_hold_on_overflow: assert property (@(posedge hclk) disable iff (!hresetn)
    (overflow_r && !both_read) |=> $stable(cap_val_r))
    else $error("capture value changed while overflow held");
  a_ovf_on_unread: assert property (@(posedge hclk) disable iff (!hresetn)
    (cap_event && unread_r && !both_read) |=> overflow_r)
    else $error("overflow not flagged on unread capture");

endmodule : tdcc_capture_chan

// file: verilog/tdcc_timer_top.sv
// tdcc_timer_top: 16-bit timer with two capture channels and pwm pin control on ahb-lite
// ******************************************************************
// How it works
// - a capture event while the previous value is unread sets that channel's overflow flag.
// - after overflow the pair keeps the oldest value until both bytes are read.
// - channel b overflow is control bit 6 and channel a is bit 5, both read only.
// - edge select 00 falling, 01 rising, 10 every 4th rising, 11 every 16th rising.
// - channel b edge select is control bits 4:3 and channel a is bits 2:1.
// - pwm enable at bit 0 forces the shared pin to output, else the direction bit rules.
// - with external source selected the counter increments on external clock falls.
// - the external clock is sampled twice per instruction cycle, delaying the increment.
// - the counter is reached only as two 8-bit halves, one per access.
// ******************************************************************
module tdcc_timer_top
(
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // capture and clock pins
  input wire logic cap_a_in,
  input wire logic cap_b_in,
  input wire logic external_counter_clock,
  // shared pwm pin
  input wire logic pwm_level,
  input wire logic port_g_direction,
  output logic shared_pwm_pin_out,
  output logic shared_pwm_pin_oe_n
);

  // ******************************************************************
  // bus address phase capture
  // ******************************************************************
  logic wr_pend_r;
  logic rd_pend_r;
  logic [11:0] addr_r;
  logic [7:0] ctrl_r;
  logic [2:0] cfg_r;
  logic [15:0] main_counter_r;
  logic [1:0] inst_cnt_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_prev_r;
  logic [31:0] rdata_nxt;
  logic instr_tick;
  logic phase_tick;
  logic ext_fall;
  logic cnt_inc;
  logic addr_ok;
  logic rd_a_lo;
  logic rd_a_hi;
  logic rd_b_lo;
  logic rd_b_hi;
  logic [15:0] cap_a_val;
  logic [15:0] cap_b_val;
  logic chan_a_overflow_flag;
  logic chan_b_overflow_flag;
  logic cap_a_ev;
  logic cap_b_ev;
  logic counter_run_bit;
  logic counter_clock_source_select;
  logic pwm_output_enable;

  assign counter_run_bit = cfg_r[tdcc_pkg::CFG_RUN_BIT];
  assign counter_clock_source_select = cfg_r[tdcc_pkg::CFG_SRC_BIT];
  assign pwm_output_enable = ctrl_r[tdcc_pkg::CTRL_PWM_BIT];
  assign hreadyout = 1'b1; // every access completes with zero wait states
  assign hresp = 1'b0;

  // only whole-word transfers are decoded, nonsequential and sequential alike
  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);

  // register the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      addr_r <= haddr;
    end
  end

  // ******************************************************************
  // read data
  // ******************************************************************
  // read data is taken from the live registers in the data phase
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (addr_r == tdcc_pkg::CTRL3_ADDR)
    begin
      rdata_nxt[tdcc_pkg::CTRL_OVFB_BIT] = chan_b_overflow_flag;
      rdata_nxt[tdcc_pkg::CTRL_OVFA_BIT] = chan_a_overflow_flag;
      rdata_nxt[4:0] = ctrl_r[4:0];
    end
    else if (addr_r == tdcc_pkg::CFG_ADDR)
      rdata_nxt[2:0] = cfg_r;
    else if (addr_r == tdcc_pkg::CNT_LO_ADDR)
      rdata_nxt[7:0] = main_counter_r[7:0];
    else if (addr_r == tdcc_pkg::CNT_HI_ADDR)
      rdata_nxt[7:0] = main_counter_r[15:8];
    else if (addr_r == tdcc_pkg::CAPA_LO_ADDR)
      rdata_nxt[7:0] = cap_a_val[7:0];
    else if (addr_r == tdcc_pkg::CAPA_HI_ADDR)
      rdata_nxt[7:0] = cap_a_val[15:8];
    else if (addr_r == tdcc_pkg::CAPB_LO_ADDR)
      rdata_nxt[7:0] = cap_b_val[7:0];
    else if (addr_r == tdcc_pkg::CAPB_HI_ADDR)
      rdata_nxt[7:0] = cap_b_val[15:8];
  end

  // zero outside a read data phase so no stale register value leaks onto the bus
  assign hrdata = rd_pend_r ? rdata_nxt : 32'h0000_0000;

  // byte reads that complete a channel's pair
  assign rd_a_lo = rd_pend_r && (addr_r == tdcc_pkg::CAPA_LO_ADDR);
  assign rd_a_hi = rd_pend_r && (addr_r == tdcc_pkg::CAPA_HI_ADDR);
  assign rd_b_lo = rd_pend_r && (addr_r == tdcc_pkg::CAPB_LO_ADDR);
  assign rd_b_hi = rd_pend_r && (addr_r == tdcc_pkg::CAPB_HI_ADDR);

  // ******************************************************************
  // control and configuration writes
  // ******************************************************************
  // overflow bits are not stored here, so writes cannot touch them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= tdcc_pkg::CTRL_RESET;
    else if (wr_pend_r && (addr_r == tdcc_pkg::CTRL3_ADDR))
      ctrl_r <= hwdata[7:0] & tdcc_pkg::CTRL_WMASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg_r <= tdcc_pkg::CFG_RESET;
    else if (wr_pend_r && (addr_r == tdcc_pkg::CFG_ADDR))
      cfg_r <= hwdata[2:0];
  end

  // ******************************************************************
  // instruction cycle and sampling phase divider
  // ******************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      inst_cnt_r <= 2'h0;
    else
      inst_cnt_r <= inst_cnt_r + 2'h1;
  end

  assign instr_tick = (inst_cnt_r == 2'(tdcc_pkg::INSTR_DIV - 1));
  assign phase_tick = (inst_cnt_r[0] == 1'(tdcc_pkg::PHASE_DIV - 1)); // twice per cycle

  // external clock: two-stage sync, then sampled on phase ticks only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_prev_r <= 1'b1;
    end
    else
    begin
      ext_s1_r <= external_counter_clock;
      ext_s2_r <= ext_s1_r;
      if (phase_tick)
        ext_prev_r <= ext_s2_r;
    end
  end

  assign ext_fall = phase_tick && ext_prev_r && !ext_s2_r;

  // ******************************************************************
  // main counter
  // ******************************************************************
  // the run bit gates both sources; software stops it for safe access
  assign cnt_inc = counter_run_bit &&
    (counter_clock_source_select ? ext_fall : instr_tick);

  // a half written this cycle is not incremented in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      main_counter_r <= 16'h0000;
    else if (wr_pend_r && (addr_r == tdcc_pkg::CNT_LO_ADDR))
      main_counter_r[7:0] <= hwdata[7:0];
    else if (wr_pend_r && (addr_r == tdcc_pkg::CNT_HI_ADDR))
      main_counter_r[15:8] <= hwdata[7:0];
    else if (cnt_inc)
      main_counter_r <= main_counter_r + 16'h0001;
  end

  // ******************************************************************
  // capture channels and pwm pin
  // ******************************************************************
  tdcc_capture_chan u_chan_a
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .cap_in(cap_a_in),
    .edge_sel(ctrl_r[tdcc_pkg::CTRL_EDA_LSB +: 2]),
    .counter_val(main_counter_r),
    .rd_lo(rd_a_lo),
    .rd_hi(rd_a_hi),
    .cap_val_r(cap_a_val),
    .overflow_r(chan_a_overflow_flag),
    .cap_event(cap_a_ev)
  );

  tdcc_capture_chan u_chan_b
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .cap_in(cap_b_in),
    .edge_sel(ctrl_r[tdcc_pkg::CTRL_EDB_LSB +: 2]),
    .counter_val(main_counter_r),
    .rd_lo(rd_b_lo),
    .rd_hi(rd_b_hi),
    .cap_val_r(cap_b_val),
    .overflow_r(chan_b_overflow_flag),
    .cap_event(cap_b_ev)
  );

  // pin drive: pwm enable overrides the direction bit (direction 1 means input)
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shared_pwm_pin_out <= 1'b0;
      shared_pwm_pin_oe_n <= 1'b1;
    end
    else
    begin
      shared_pwm_pin_out <= pwm_level;
      shared_pwm_pin_oe_n <= !pwm_output_enable && port_g_direction;
    end
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  a_pwm_forces_out: assert property (@(posedge hclk) disable iff (!hresetn)
    pwm_output_enable |=> !shared_pwm_pin_oe_n)
    else $error("pwm enable did not force pin output");
  a_pin_follows_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    !pwm_output_enable |=> (shared_pwm_pin_oe_n == $past(port_g_direction)))
    else $error("pin enable ignores direction bit");
  a_stop_holds_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (!counter_run_bit && !wr_pend_r) |=> $stable(main_counter_r))
    else $error("counter moved while stopped");
  a_internal_tick_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_inc && !counter_clock_source_select) |=> !cnt_inc [*3])
    else $error("internal count faster than instruction rate");
  a_ext_one_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (counter_clock_source_select && counter_run_bit && ext_fall && !wr_pend_r)
    |=> main_counter_r == $past(main_counter_r) + 16'h0001)
    else $error("external fall did not step counter");
  a_ovf_read_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == tdcc_pkg::CTRL3_ADDR && chan_b_overflow_flag)
    |=> chan_b_overflow_flag)
    else $error("overflow flag cleared by write");
  a_ovf_b_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_r && addr_r == tdcc_pkg::CTRL3_ADDR)
    |-> hrdata[tdcc_pkg::CTRL_OVFB_BIT] == chan_b_overflow_flag)
    else $error("channel b overflow not at bit 6");
  a_okay_resp: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave stalled or erred");
  a_cnt_lo_half: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == tdcc_pkg::CNT_LO_ADDR)
    |=> main_counter_r == {$past(main_counter_r[15:8]), $past(hwdata[7:0])})
    else $error("low half write touched the wrong bits");
  a_cnt_hi_half: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == tdcc_pkg::CNT_HI_ADDR)
    |=> main_counter_r == {$past(hwdata[7:0]), $past(main_counter_r[7:0])})
    else $error("high half write touched the wrong bits");

  c_cap_a: cover property (@(posedge hclk) disable iff (!hresetn) cap_a_ev);
  c_cap_b: cover property (@(posedge hclk) disable iff (!hresetn) cap_b_ev);
  c_ovf_b: cover property (@(posedge hclk) disable iff (!hresetn) $rose(chan_b_overflow_flag));
  c_ext_cnt: cover property (@(posedge hclk) disable iff (!hresetn)
    counter_clock_source_select && cnt_inc);
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    cnt_inc && main_counter_r == 16'hffff);

endmodule : tdcc_timer_top

// file: tb/tdcc_far_side.sv
// tdcc_far_side: model of the capture pins and the external counter clock source
module tdcc_far_side
(
  // clock
  input wire logic hclk,
  // pins toward the timer
  output logic cap_a_in,
  output logic cap_b_in,
  output logic external_counter_clock
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle levels: capture pins low, external clock parked high so no stray fall
  initial
  begin
    cap_a_in = 1'b0;
    cap_b_in = 1'b0;
    external_counter_clock = 1'b1;
  end

  // one rise and one fall on a capture pin, each level held for hold clocks
  task automatic cap_pulse(input int ch, input int hold);
    if (ch == 0) cap_a_in <= 1'b1;
    else cap_b_in <= 1'b1;
    repeat (hold) @(posedge hclk);
    if (ch == 0) cap_a_in <= 1'b0;
    else cap_b_in <= 1'b0;
    repeat (hold) @(posedge hclk);
  endtask : cap_pulse

  // n falling edges; hold of four or more clocks lets the twice-per-cycle sampler see each level
  task automatic ext_falls(input int n, input int hold);
    repeat (n)
    begin
      external_counter_clock <= 1'b0;
      repeat (hold) @(posedge hclk);
      external_counter_clock <= 1'b1;
      repeat (hold) @(posedge hclk);
    end
  endtask : ext_falls

endmodule : tdcc_far_side

// file: tb/tdcc_timer_top_test.sv
// tdcc_timer_top_test: self-checking bench with a behavioural model of the capture timer
module tdcc_timer_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ******************************************************************
  // signals and model state
  // ******************************************************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic cap_a_in;
  logic cap_b_in;
  logic ext_clk;
  logic pwm_level = 1'b0;
  logic port_g_direction = 1'b1;
  logic pin_out;
  logic pin_oe_n;
  logic [31:0] rd;
  logic [31:0] rnd;
  logic [31:0] seed = 32'h26d8;
  int n_fail = 0;
  int num_checks = 0;
  int m_cnt;
  int m_ctrl;
  int m_mode;
  int m_cap[2];
  int m_unread[2];
  int m_ovf[2];
  int m_rises[2];

  // clock and the single slave's ready fed back as the bus ready
  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  tdcc_timer_top tdcc_timer_top_inst
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cap_a_in(cap_a_in), .cap_b_in(cap_b_in),
    .external_counter_clock(ext_clk), .pwm_level(pwm_level),
    .port_g_direction(port_g_direction), .shared_pwm_pin_out(pin_out),
    .shared_pwm_pin_oe_n(pin_oe_n)
  );

  tdcc_far_side tdcc_far_side_inst
  (
    .hclk(hclk), .cap_a_in(cap_a_in), .cap_b_in(cap_b_in), .external_counter_clock(ext_clk)
  );

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xrand

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word

  // the free-running divider phase is unknown, so a tick count is only known to a window
  task automatic cmp_range(input logic [31:0] got, input int lo, input int hi, input string what);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : cmp_range

  // single word transfer; entered just after a rising edge, returns on the data edge
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rchk(input logic [11:0] a, input int e, input string what);
    ahb(a, 1'b0, 32'h0);
    cmp_word(rd, e, what);
  endtask : rchk

  // counter is written only while stopped, low half then high half
  task automatic set_cnt(input int v);
    ahb(tdcc_pkg::CNT_LO_ADDR, 1'b1, v & 255);
    ahb(tdcc_pkg::CNT_HI_ADDR, 1'b1, (v >> 8) & 255);
    m_cnt = v;
  endtask : set_cnt

  task automatic rd_cnt(output logic [31:0] v);
    ahb(tdcc_pkg::CNT_LO_ADDR, 1'b0, 32'h0);
    v = rd;
    ahb(tdcc_pkg::CNT_HI_ADDR, 1'b0, 32'h0);
    v = v | (rd << 8);
  endtask : rd_cnt

  task automatic pulse(input int ch);
    int fire;
    rnd = xrand();
    tdcc_far_side_inst.cap_pulse(ch, 4 + rnd[1:0]);
    m_rises[ch]++;
    fire = m_mode < 2 || m_rises[ch] % (m_mode == 2 ? 4 : 16) == 0;
    if (fire && m_unread[ch] != 0) m_ovf[ch] = 1;
    else if (fire)
    begin
      m_cap[ch] = m_cnt;
      m_unread[ch] = 1;
    end
  endtask : pulse

  task automatic chk_ovf();
    rchk(tdcc_pkg::CTRL3_ADDR, m_ctrl | (m_ovf[0] << 5) | (m_ovf[1] << 6), "ctrl");
  endtask : chk_ovf

  // both halves of a pair; reading them ends any overflow hold
  task automatic rd_pair(input int ch);
    rchk(ch == 0 ? tdcc_pkg::CAPA_LO_ADDR : tdcc_pkg::CAPB_LO_ADDR, m_cap[ch] & 255, "cap lo");
    rchk(ch == 0 ? tdcc_pkg::CAPA_HI_ADDR : tdcc_pkg::CAPB_HI_ADDR, m_cap[ch] >> 8, "cap hi");
    m_unread[ch] = 0;
    m_ovf[ch] = 0;
  endtask : rd_pair

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    m_cnt = 0;
    m_ctrl = 0;
    m_cap = '{0, 0};
    m_unread = '{0, 0};
    m_ovf = '{0, 0};
    m_rises = '{0, 0};
  endtask : do_reset

  // ******************************************************************
  // tests
  // ******************************************************************
  // watchdog: whole run needs well under 20k clocks
  initial
  begin
    #500000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    do_reset();
    // reset values, write mask, read-only flags, unmapped place
    cmp_word({hresp, pin_oe_n}, 32'h1, "bus resp and pin enable");
    rchk(tdcc_pkg::CFG_ADDR, 0, "cfg reset");
    ahb(tdcc_pkg::CTRL3_ADDR, 1'b1, 32'hff);
    rchk(tdcc_pkg::CTRL3_ADDR, 32'h1f, "ctrl mask");
    ahb(12'h040, 1'b1, 32'hff);
    rchk(12'h040, 0, "unmapped");
    ahb(tdcc_pkg::CTRL3_ADDR, 1'b1, 32'h0);
    $display("test registers done");
    // pin ownership for every enable and direction pair
    for (int i = 0; i < 4; i++)
    begin
      ahb(tdcc_pkg::CTRL3_ADDR, 1'b1, i & 1);
      rnd = xrand();
      port_g_direction <= i[1];
      pwm_level <= rnd[0];
      repeat (2) @(posedge hclk);
      cmp_word(pin_oe_n, !i[0] && i[1], "pin enable");
      cmp_word(pin_out, rnd[0], "pin level");
    end
    ahb(tdcc_pkg::CTRL3_ADDR, 1'b1, 32'h0);
    $display("test pwm pin done");
    // internal count: about one tick per four clocks over 42 clocks of run
    rnd = xrand() & 32'h7fff;
    set_cnt(rnd);
    ahb(tdcc_pkg::CFG_ADDR, 1'b1, 32'h1);
    repeat (40) @(posedge hclk);
    ahb(tdcc_pkg::CFG_ADDR, 1'b1, 32'h0);
    rd_cnt(rd);
    cmp_range(rd, m_cnt + 10, m_cnt + 11, "internal count");
    m_cnt = rd;
    repeat (12) @(posedge hclk);
    rd_cnt(rd);
    cmp_word(rd, m_cnt, "stopped count");
    $display("test internal count done");
    // external count: exact number of falls, no internal ticks mixed in
    rnd = xrand();
    set_cnt(rnd & 32'h7fff);
    ahb(tdcc_pkg::CFG_ADDR, 1'b1, 32'h3);
    tdcc_far_side_inst.ext_falls(1 + rnd[18:16], 4 + rnd[21:20]);
    repeat (8) @(posedge hclk);
    ahb(tdcc_pkg::CFG_ADDR, 1'b1, 32'h2);
    rd_cnt(rd);
    cmp_word(rd, m_cnt + 1 + rnd[18:16], "external count");
    ahb(tdcc_pkg::CFG_ADDR, 1'b1, 32'h0);
    $display("test external count done");
    // every edge code on both channels, fresh reset so the prescalers start at zero
    for (int m = 0; m < 4; m++)
    begin
      do_reset();
      m_mode = m;
      m_ctrl = (m << 1) | (m << 3);
      ahb(tdcc_pkg::CTRL3_ADDR, 1'b1, m_ctrl);
      for (int ch = 0; ch < 2; ch++)
      begin
        for (int k = 0; k < 16; k++)
        begin
          set_cnt(xrand() & 32'hffff);
          pulse(ch);
        end
        chk_ovf();
        ahb(tdcc_pkg::CTRL3_ADDR, 1'b1, m_ctrl | 32'h60);
        chk_ovf();
        rd_pair(ch);
        chk_ovf();
        set_cnt(xrand() & 32'hffff);
        repeat (m < 2 ? 1 : (m == 2 ? 4 : 16)) pulse(ch);
        rd_pair(ch);
      end
      $display("test capture mode %0d done", m);
    end
    finish_test();
  end

endmodule : tdcc_timer_top_test
